//--- rtl/rxc_pkg.sv
package rxc_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_STRENGTH_LEVEL = 8'h0f;
  localparam logic [7:0] OFF_FILTER_BW = 8'h10;
  localparam logic [7:0] OFF_POLY_CENTER = 8'h11;
  localparam logic [7:0] OFF_SYNC_CFG = 8'h12;
  localparam logic [7:0] OFF_RSVD = 8'h13;
  localparam logic [7:0] OFF_STRENGTH = 8'h14;
  localparam logic [7:0] OFF_OOK_CFG = 8'h15;
  localparam logic [7:0] OFF_PATTERN0 = 8'h16;
  localparam logic [7:0] OFF_PATTERN1 = 8'h17;
  localparam logic [7:0] OFF_PATTERN2 = 8'h18;
  localparam logic [7:0] OFF_PATTERN3 = 8'h19;

  // ****************************************
  // Values after reset
  // ****************************************
  localparam logic [7:0] RST_FILTER_BW = 8'ha3;
  localparam logic [7:0] RST_POLY_CENTER = 8'h38;
  localparam logic [7:0] RST_SYNC_CFG = 8'h18;
  localparam logic [7:0] RST_RSVD = 8'h07;
  localparam logic [7:0] RST_OOK_CFG = 8'h00;
  localparam logic [7:0] RST_STRENGTH_LEVEL = 8'h00;
  localparam logic [7:0] RST_PATTERN = 8'h00;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int PASSIVE_LSB = 4;
  localparam int RECEIVER_LSB = 0;
  localparam int CENTER_LSB = 4;
  localparam int POLY_EN_BIT = 7;
  localparam int BITSYNC_OFF_BIT = 6;
  localparam int SYNC_ON_BIT = 5;
  localparam int SYNC_LEN_LSB = 3;
  localparam int SYNC_TOL_LSB = 1;
  localparam int STEP_LSB = 5;
  localparam int RATE_LSB = 2;
  localparam int CUTOFF_LSB = 0;

  // ****************************************
  // Counts
  // ****************************************
  localparam int SYNC_MAX_BITS = 32;
  localparam logic [3:0] SUBCHIP_PER_CHIP = 4'h8;

endpackage

//--- rtl/rxc_regs.sv
`timescale 1ns/1ps
// Notes on behaviour
// R1: Sync recognition runs only while the sync enable bit is one; reset off.
// R2: Sync length code 00..11 selects 8, 16, 24, 32 bits; reset 11.
// R3: Tolerance code allows zero to three mismatched bits; reset zero.
// R4: Bit synchronizer active in continuous receive unless disable bit set.
// R5: Signal strength is read-only, half dB per step; host never writes it.
// R6: Threshold step codes map 0.5 to 6.0 dB; reset code 000.
// R7: Decrement rate once per 1..8 chips or 2..16 times per chip; 16 per chip clamps to every sub-chip tick, 8 per chip.
// R8: Averaging cutoff 00 or 11; 01 and 10 reserved for host.
// R9: Polyphase enable bit switches the filter on; resets off.
// R10: Passive bandwidth code in upper nibble of register 16; reset 1010.
// R11: Receiver bandwidth code in lower nibble of register 16; reset 0011.
// R12: Polyphase centre code in upper nibble of register 17; reset 0011.
// R13: Sync pattern in four bytes, first most significant, used per length.
// R14: Strength interrupt level uses strength coding; resets to zero.
// R15: Match when recent bits differ from pattern within tolerance.
module rxc_regs (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic rx_bit,
  input wire logic rx_bit_valid,
  input wire logic cont_rx_mode,
  input wire logic [7:0] strength_in,
  input wire logic chip_tick,
  input wire logic subchip_tick,
  output logic [3:0] passive_bw_code,
  output logic [3:0] receiver_bw_code,
  output logic [3:0] polyphase_center_code,
  output logic polyphase_enable,
  output logic bitsync_active,
  output logic [2:0] onoff_threshold_step,
  output logic [3:0] step_half_db,
  output logic threshold_dec_tick,
  output logic [1:0] onoff_average_cutoff,
  output logic sync_match,
  output logic strength_above_level
);

  // ****************************************
  // Decoding
  // ****************************************
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  function automatic logic [3:0] step_lut(input logic [2:0] code);
    logic [3:0] v;
    v = 4'h0;
    case (code)
      3'h0: v = 4'h1;
      3'h1: v = 4'h2;
      3'h2: v = 4'h3;
      3'h3: v = 4'h4;
      3'h4: v = 4'h6;
      3'h5: v = 4'h8;
      3'h6: v = 4'ha;
      default: v = 4'hc;
    endcase
    return v;
  endfunction

  logic [7:0] filter_bw_r;
  logic [7:0] poly_center_r;
  logic [7:0] sync_cfg_r;
  logic [7:0] rsvd_r;
  logic [7:0] strength_value_r;
  logic [7:0] ook_cfg_r;
  logic [7:0] level_r;
  logic [7:0] pattern_r [4];
  logic [7:0] rdata_r;
  logic bitsync_r;
  logic [3:0] step_r;
  logic [3:0] rate_cnt_r;
  logic dec_tick_r;
  logic above_r;

  wire wr_filter = reg_wr && hit(reg_addr, rxc_pkg::OFF_FILTER_BW);
  wire wr_poly = reg_wr && hit(reg_addr, rxc_pkg::OFF_POLY_CENTER);
  wire wr_sync = reg_wr && hit(reg_addr, rxc_pkg::OFF_SYNC_CFG);
  wire wr_rsvd = reg_wr && hit(reg_addr, rxc_pkg::OFF_RSVD);
  wire wr_ook = reg_wr && hit(reg_addr, rxc_pkg::OFF_OOK_CFG);
  wire wr_level = reg_wr && hit(reg_addr, rxc_pkg::OFF_STRENGTH_LEVEL);
  wire [31:0] pattern_word = {pattern_r[0], pattern_r[1], pattern_r[2], pattern_r[3]};

  wire [7:0] pattern_rd =
    hit(reg_addr, rxc_pkg::OFF_PATTERN0) ? pattern_r[0] :
    hit(reg_addr, rxc_pkg::OFF_PATTERN1) ? pattern_r[1] :
    hit(reg_addr, rxc_pkg::OFF_PATTERN2) ? pattern_r[2] :
    hit(reg_addr, rxc_pkg::OFF_PATTERN3) ? pattern_r[3] : 8'h00;
  // Unmapped addresses read zero
  wire [7:0] rd_mux =
    hit(reg_addr, rxc_pkg::OFF_STRENGTH_LEVEL) ? level_r :
    hit(reg_addr, rxc_pkg::OFF_FILTER_BW) ? filter_bw_r :
    hit(reg_addr, rxc_pkg::OFF_POLY_CENTER) ? poly_center_r :
    hit(reg_addr, rxc_pkg::OFF_SYNC_CFG) ? sync_cfg_r :
    hit(reg_addr, rxc_pkg::OFF_RSVD) ? rsvd_r :
    hit(reg_addr, rxc_pkg::OFF_STRENGTH) ? strength_value_r :
    hit(reg_addr, rxc_pkg::OFF_OOK_CFG) ? ook_cfg_r : pattern_rd;

  // ****************************************
  // Configuration registers
  // ****************************************
  // R10 R11 bandwidth codes
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      filter_bw_r <= rxc_pkg::RST_FILTER_BW;
    end else if (wr_filter) begin
      filter_bw_r <= reg_wdata;
    end
  end

  // R12 centre code
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      poly_center_r <= rxc_pkg::RST_POLY_CENTER;
    end else if (wr_poly) begin
      poly_center_r <= reg_wdata;
    end
  end

  // R9 polyphase enable with sync fields
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sync_cfg_r <= rxc_pkg::RST_SYNC_CFG;
    end else if (wr_sync) begin
      sync_cfg_r <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rsvd_r <= rxc_pkg::RST_RSVD;
    end else if (wr_rsvd) begin
      rsvd_r <= reg_wdata;
    end
  end

  // R8 cutoff stored as written
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ook_cfg_r <= rxc_pkg::RST_OOK_CFG;
    end else if (wr_ook) begin
      ook_cfg_r <= reg_wdata;
    end
  end

  // R14 strength level
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      level_r <= rxc_pkg::RST_STRENGTH_LEVEL;
    end else if (wr_level) begin
      level_r <= reg_wdata;
    end
  end

  // R13 pattern bytes
  for (genvar g = 0; g < 4; g++) begin : g_pattern
    wire [7:0] off = rxc_pkg::OFF_PATTERN0 + 8'(g);
    always_ff @(posedge clk) begin
      if (!rst_b) begin
        pattern_r[g] <= rxc_pkg::RST_PATTERN;
      end else if (reg_wr && hit(reg_addr, off)) begin
        pattern_r[g] <= reg_wdata;
      end
    end
  end

  // ****************************************
  // Status and read port
  // ****************************************
  // R5 strength tracks the input, writes ignored
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      strength_value_r <= 8'h00;
      above_r <= 1'b0;
    end else begin
      strength_value_r <= strength_in;
      above_r <= strength_value_r > level_r;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // ****************************************
  // Demodulator controls
  // ****************************************
  // R4 bit synchronizer gate
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bitsync_r <= 1'b0;
    end else begin
      bitsync_r <= cont_rx_mode && !sync_cfg_r[rxc_pkg::BITSYNC_OFF_BIT];
    end
  end

  // R6 step in half dB
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      step_r <= 4'h1;
    end else begin
      step_r <= step_lut(ook_cfg_r[rxc_pkg::STEP_LSB +: 3]);
    end
  end

  // R7 decrement rate: slow codes count chips, fast codes count sub-chip ticks
  wire [2:0] rate_code = ook_cfg_r[rxc_pkg::RATE_LSB +: 3];
  wire rate_src = rate_code[2] ? subchip_tick : chip_tick;
  // Fast codes: 2, 4, 8 per chip; 16 per chip clamps to every sub-chip tick
  wire [3:0] fast_period = rxc_pkg::SUBCHIP_PER_CHIP >> ({1'b0, rate_code[1:0]} + 3'h1);
  wire [3:0] rate_period = !rate_code[2] ? (4'h1 << rate_code[1:0]) :
                           (fast_period == 4'h0) ? 4'h1 : fast_period;
  wire rate_last = rate_cnt_r >= (rate_period - 4'h1);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rate_cnt_r <= 4'h0;
      dec_tick_r <= 1'b0;
    end else begin
      dec_tick_r <= rate_src && rate_last;
      if (rate_src) begin
        rate_cnt_r <= rate_last ? 4'h0 : rate_cnt_r + 4'h1;
      end
    end
  end

  // ****************************************
  // Sync detector
  // ****************************************
  rxc_sync_if sync_bus ();

  // R1 R2 R3 fields steer the detector
  assign sync_bus.sync_pattern = pattern_word;
  assign sync_bus.sync_len = sync_cfg_r[rxc_pkg::SYNC_LEN_LSB +: 2];
  assign sync_bus.sync_tol = sync_cfg_r[rxc_pkg::SYNC_TOL_LSB +: 2];
  assign sync_bus.sync_enable = sync_cfg_r[rxc_pkg::SYNC_ON_BIT];
  assign sync_bus.rx_bit = rx_bit;
  assign sync_bus.rx_bit_valid = rx_bit_valid;

  rxc_sync_det u_det (
    .clk(clk),
    .rst_b(rst_b),
    .bus(sync_bus.det)
  );

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_rdata = rdata_r;
  assign passive_bw_code = filter_bw_r[rxc_pkg::PASSIVE_LSB +: 4];
  assign receiver_bw_code = filter_bw_r[rxc_pkg::RECEIVER_LSB +: 4];
  assign polyphase_center_code = poly_center_r[rxc_pkg::CENTER_LSB +: 4];
  assign polyphase_enable = sync_cfg_r[rxc_pkg::POLY_EN_BIT];
  assign bitsync_active = bitsync_r;
  assign onoff_threshold_step = ook_cfg_r[rxc_pkg::STEP_LSB +: 3];
  assign step_half_db = step_r;
  assign threshold_dec_tick = dec_tick_r;
  assign onoff_average_cutoff = ook_cfg_r[rxc_pkg::CUTOFF_LSB +: 2];
  assign sync_match = sync_bus.sync_match;
  assign strength_above_level = above_r;

  // ****************************************
  // Checks
  // ****************************************
  a_sync_cfg_reset: assert property ( // R2
    @(posedge clk) !rst_b |=> sync_cfg_r == rxc_pkg::RST_SYNC_CFG)
    else $error("sync config reset value wrong");

  a_strength_read: assert property ( // R5
    @(posedge clk) disable iff (!rst_b)
    reg_rd && hit(reg_addr, rxc_pkg::OFF_STRENGTH) |=> reg_rdata == $past(strength_value_r))
    else $error("strength read mismatch");

  a_bitsync_gate: assert property ( // R4
    @(posedge clk) disable iff (!rst_b)
    cont_rx_mode && !sync_cfg_r[rxc_pkg::BITSYNC_OFF_BIT] |=> bitsync_active)
    else $error("bit synchronizer not active");

  a_poly_write: assert property ( // R9
    @(posedge clk) disable iff (!rst_b)
    wr_sync |=> polyphase_enable == $past(reg_wdata[rxc_pkg::POLY_EN_BIT]))
    else $error("polyphase enable not written");

  a_bw_write: assert property ( // R10
    @(posedge clk) disable iff (!rst_b)
    wr_filter |=> {passive_bw_code, receiver_bw_code} == $past(reg_wdata))
    else $error("bandwidth codes not written");

  a_center_write: assert property ( // R12
    @(posedge clk) disable iff (!rst_b)
    wr_poly |=> polyphase_center_code == $past(reg_wdata[7:4]))
    else $error("centre code not written");

  a_step_map: assert property ( // R6
    @(posedge clk) disable iff (!rst_b)
    $stable(ook_cfg_r) && ook_cfg_r[7:5] == 3'h4 |=> step_half_db == 4'h6)
    else $error("threshold step map wrong");

  a_rate_every_chip: assert property ( // R7
    @(posedge clk) disable iff (!rst_b)
    rate_code == 3'h0 && chip_tick |=> threshold_dec_tick)
    else $error("decrement tick missing");

  a_level_compare: assert property ( // R14
    @(posedge clk) disable iff (!rst_b)
    ##1 strength_above_level == ($past(strength_value_r) > $past(level_r)))
    else $error("level compare wrong");

endmodule

//--- rtl/rxc_sync_det.sv
`timescale 1ns/1ps
module rxc_sync_det (
  input wire logic clk,
  input wire logic rst_b,
  rxc_sync_if.det bus
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [5:0] ones_count(input logic [31:0] v);
    logic [5:0] n;
    n = 6'h00;
    for (int i = 0; i < 32; i++) begin
      n = n + {5'h00, v[i]};
    end
    return n;
  endfunction

  logic [31:0] shift_r;
  logic [31:0] shift_nxt;
  logic [5:0] fill_r;
  logic [5:0] fill_nxt;
  logic match_r;
  logic match_nxt;
  wire [5:0] len_bits = {1'b0, bus.sync_len, 3'h0} + 6'h08;
  wire [31:0] len_mask = 32'hffffffff >> (6'h20 - len_bits);
  // R13 first byte is most significant, unused bytes drop out
  wire [31:0] pattern_aligned = bus.sync_pattern >> (6'h20 - len_bits);
  wire [31:0] diff = (shift_nxt ^ pattern_aligned) & len_mask;
  wire [5:0] errors = ones_count(diff);

  assign shift_nxt = {shift_r[30:0], bus.rx_bit};
  assign fill_nxt = (fill_r == 6'h20) ? fill_r : fill_r + 6'h01;
  // R15 match when window full and errors within tolerance
  assign match_nxt = bus.sync_enable && bus.rx_bit_valid && (fill_nxt >= len_bits)
                     && (errors <= {4'h0, bus.sync_tol});
  assign bus.sync_match = match_r;

  // ****************************************
  // Bit window
  // ****************************************
  // R1 recognition only while enabled
  always_ff @(posedge clk) begin
    if (!rst_b || !bus.sync_enable) begin
      shift_r <= 32'h00000000;
      fill_r <= 6'h00;
    end else if (bus.rx_bit_valid) begin
      shift_r <= shift_nxt;
      fill_r <= fill_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      match_r <= 1'b0;
    end else begin
      match_r <= match_nxt;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_off_no_match: assert property ( // R1
    @(posedge clk) disable iff (!rst_b) !bus.sync_enable |=> !match_r)
    else $error("sync match while recognition off");

  a_match_errors: assert property ( // R3
    @(posedge clk) disable iff (!rst_b)
    match_r |-> $past(errors) <= {4'h0, $past(bus.sync_tol)})
    else $error("sync match with too many errors");

  a_match_length: assert property ( // R2
    @(posedge clk) disable iff (!rst_b)
    match_r |-> $past(fill_nxt) >= $past(len_bits) && $past(bus.rx_bit_valid))
    else $error("sync match before length bits received");

endmodule

//--- rtl/rxc_sync_if.sv
`timescale 1ns/1ps
interface rxc_sync_if;
  logic [31:0] sync_pattern;
  logic [1:0] sync_len;
  logic [1:0] sync_tol;
  logic sync_enable;
  logic rx_bit;
  logic rx_bit_valid;
  logic sync_match;

  modport cfg (
    output sync_pattern,
    output sync_len,
    output sync_tol,
    output sync_enable,
    output rx_bit,
    output rx_bit_valid,
    input sync_match
  );

  modport det (
    input sync_pattern,
    input sync_len,
    input sync_tol,
    input sync_enable,
    input rx_bit,
    input rx_bit_valid,
    output sync_match
  );
endinterface

//--- testbench/rxc_host_model.sv
`timescale 1ns/1ps
// ****************************************
// Host side of the register port
// ****************************************
module rxc_host_model (
  input wire logic clk,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a === rxc_pkg::OFF_STRENGTH) return;
    if (a === rxc_pkg::OFF_OOK_CFG && (d[1:0] === 2'h1 || d[1:0] === 2'h2)) return;
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    // Released lines show no stale value
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
endmodule

//--- testbench/tb.sv
`timescale 1ns/1ps
module tb;
  logic clk;
  logic rst_b;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic rx_bit;
  logic rx_bit_valid;
  logic cont_rx_mode;
  logic [7:0] strength_in;
  logic chip_tick;
  logic subchip_tick;
  logic [3:0] passive_bw_code;
  logic [3:0] receiver_bw_code;
  logic [3:0] polyphase_center_code;
  logic polyphase_enable;
  logic bitsync_active;
  logic [2:0] onoff_threshold_step;
  logic [3:0] step_half_db;
  logic threshold_dec_tick;
  logic [1:0] onoff_average_cutoff;
  logic sync_match;
  logic strength_above_level;
  logic [15:0] cyc;
  int cycles;
  int mismatches;
  int compares;

  rxc_host_model rxc_host_model_i (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  rxc_regs rxc_regs_i (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_bit(rx_bit),
    .rx_bit_valid(rx_bit_valid), .cont_rx_mode(cont_rx_mode), .strength_in(strength_in),
    .chip_tick(chip_tick), .subchip_tick(subchip_tick), .passive_bw_code(passive_bw_code),
    .receiver_bw_code(receiver_bw_code), .polyphase_center_code(polyphase_center_code),
    .polyphase_enable(polyphase_enable), .bitsync_active(bitsync_active),
    .onoff_threshold_step(onoff_threshold_step), .step_half_db(step_half_db),
    .threshold_dec_tick(threshold_dec_tick), .onoff_average_cutoff(onoff_average_cutoff),
    .sync_match(sync_match), .strength_above_level(strength_above_level));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ****************************************
  // Chip ticks, 8 subchip ticks per chip, timeout
  // ****************************************
  always @(posedge clk) begin
    cyc <= cyc + 16'h1;
    chip_tick <= (cyc[3:0] === 4'hf);
    subchip_tick <= cyc[0];
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic t_reset();
    logic [7:0] d;
    logic [7:0] a;
    logic [7:0] tab [12] = '{8'h00, 8'ha3, 8'h38, 8'h18, 8'h07, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 12; i++) begin
      a = (i == 11) ? 8'h20 : 8'h0f + 8'(i);
      rxc_host_model_i.rd(a, d);
      check(d, tab[i]);
    end
    check(passive_bw_code, 4'ha);
    check(receiver_bw_code, 4'h3);
    check(polyphase_center_code, 4'h3);
    check(polyphase_enable, 1'b0);
    check(step_half_db, 4'h1);
    check(onoff_average_cutoff, 2'h0);
  endtask

  task automatic t_fields();
    logic [7:0] d;
    rxc_host_model_i.wr(rxc_pkg::OFF_FILTER_BW, 8'h5c);
    rxc_host_model_i.wr(rxc_pkg::OFF_POLY_CENTER, 8'hf8);
    rxc_host_model_i.wr(rxc_pkg::OFF_SYNC_CFG, 8'h80);
    rxc_host_model_i.wr(8'h20, 8'hff);
    settle();
    check(passive_bw_code, 4'h5);
    check(receiver_bw_code, 4'hc);
    check(polyphase_center_code, 4'hf);
    check(polyphase_enable, 1'b1);
    rxc_host_model_i.rd(rxc_pkg::OFF_FILTER_BW, d);
    check(d, 8'h5c);
    rxc_host_model_i.rd(8'h20, d);
    check(d, 8'h00);
    rxc_host_model_i.wr(rxc_pkg::OFF_SYNC_CFG, 8'h18);
    settle();
    check(polyphase_enable, 1'b0);
  endtask

  task automatic t_strength();
    logic [7:0] d;
    @(posedge clk);
    strength_in <= 8'h42;
    rxc_host_model_i.wr(rxc_pkg::OFF_STRENGTH_LEVEL, 8'h41);
    settle();
    check(strength_above_level, 1'b1);
    rxc_host_model_i.rd(rxc_pkg::OFF_STRENGTH, d);
    check(d, 8'h42);
    rxc_host_model_i.wr(rxc_pkg::OFF_STRENGTH_LEVEL, 8'h42);
    settle();
    check(strength_above_level, 1'b0);
  endtask

  task automatic t_bitsync();
    @(posedge clk);
    cont_rx_mode <= 1'b1;
    rxc_host_model_i.wr(rxc_pkg::OFF_SYNC_CFG, 8'h00);
    settle();
    check(bitsync_active, 1'b1);
    rxc_host_model_i.wr(rxc_pkg::OFF_SYNC_CFG, 8'h40);
    settle();
    check(bitsync_active, 1'b0);
    rxc_host_model_i.wr(rxc_pkg::OFF_SYNC_CFG, 8'h00);
    cont_rx_mode <= 1'b0;
    settle();
    check(bitsync_active, 1'b0);
  endtask

  task automatic t_step();
    logic [7:0] d;
    logic [1:0] cut;
    logic [3:0] hd [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'ha, 4'hc};
    for (int c = 0; c < 8; c++) begin
      cut = c[0] ? 2'h3 : 2'h0;
      rxc_host_model_i.wr(rxc_pkg::OFF_OOK_CFG, {c[2:0], 3'h0, cut});
      settle();
      check(onoff_threshold_step, c[2:0]);
      check(step_half_db, hd[c]);
      check(onoff_average_cutoff, cut);
      rxc_host_model_i.rd(rxc_pkg::OFF_OOK_CFG, d);
      check(d, {c[2:0], 3'h0, cut});
    end
  endtask

  task automatic t_rate();
    int n;
    for (int c = 0; c < 8; c++) begin
      rxc_host_model_i.wr(rxc_pkg::OFF_OOK_CFG, {3'h0, c[2:0], 2'h0});
      repeat (128) @(posedge clk);
      n = 0;
      for (int k = 0; k < 128; k++) begin
        @(posedge clk);
        #1;
        if (threshold_dec_tick === 1'b1) n++;
      end
      // Code 7 limited to one decrement per sub-chip tick
      check(n, (c < 4) ? (8 >> c) : ((c == 7) ? 64 : (16 << (c - 4))));
    end
  endtask

  task automatic t_sync();
    int hits;
    logic [7:0] cfg [9] = '{8'h18, 8'h20, 8'h20, 8'h22, 8'h2c, 8'h2a, 8'h36, 8'h38, 8'h38};
    logic [31:0] w [9] = '{32'ha53c960f, 32'ha5, 32'ha4, 32'ha4, 32'ha53f, 32'ha53f,
      32'ha53c91, 32'ha53c960f, 32'ha53c960e};
    int n [9] = '{32, 8, 8, 8, 16, 16, 24, 32, 32};
    int ex [9] = '{0, 1, 0, 1, 1, 0, 1, 1, 0};
    rxc_host_model_i.wr(rxc_pkg::OFF_PATTERN0, 8'ha5);
    rxc_host_model_i.wr(rxc_pkg::OFF_PATTERN1, 8'h3c);
    rxc_host_model_i.wr(rxc_pkg::OFF_PATTERN2, 8'h96);
    rxc_host_model_i.wr(rxc_pkg::OFF_PATTERN3, 8'h0f);
    for (int i = 0; i < 9; i++) begin
      rxc_host_model_i.wr(rxc_pkg::OFF_SYNC_CFG, 8'h00);
      rxc_host_model_i.wr(rxc_pkg::OFF_SYNC_CFG, cfg[i]);
      hits = 0;
      for (int b = n[i] - 1; b >= 0; b--) begin
        @(posedge clk);
        rx_bit_valid <= 1'b1;
        rx_bit <= w[i][b];
        @(posedge clk);
        rx_bit_valid <= 1'b0;
        rx_bit <= ~w[i][b];
        #1;
        if (sync_match === 1'b1) hits++;
      end
      check(hits, ex[i]);
    end
  endtask

  task automatic print_verdict();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    rst_b = 1'b0;
    rx_bit = 1'b0;
    rx_bit_valid = 1'b0;
    cont_rx_mode = 1'b0;
    strength_in = 8'h00;
    chip_tick = 1'b0;
    subchip_tick = 1'b0;
    cyc = 16'h0;
    cycles = 0;
    mismatches = 0;
    compares = 0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_fields();
    t_strength();
    t_bitsync();
    t_step();
    t_rate();
    t_sync();
    print_verdict();
  end
endmodule
